// ==== hdl/access_guard_pkg.sv ====
/*
  Shared constants, field layouts and helper functions for the peripheral
  bridge and I/O port access guard.
  Assumes one 100 MHz system clock and synchronous active-low resets.
*/
// How it works
// - bridge forwards master transactions to peripheral slots
// - every slot owns its own rights word
// - read/write rights per master and mode
// - violating bridge access blocked, ends with error
// - rights writes take effect only when privileged
// - I/O pins grouped in ports of eight
// - each port keeps rights per master, mode
// - ports reachable via bridge and core port
// - core port: denied read zero, write ignored
// - denied bridge access to port gives error
// - core starts privileged secure after any reset
// - lock freezes configuration until power-on reset
// - three modes: priv secure, user secure, nonsecure
// - rights kept per master: core and DMA
package access_guard_pkg;

  // bus masters
  localparam logic       MASTER_CORE   = 1'b0;
  localparam logic       MASTER_DMA    = 1'b1;

  // access modes
  typedef enum logic [1:0]
  {
    MODE_PRIV_SECURE = 2'h0,
    MODE_USER_SECURE = 2'h1,
    MODE_USER_NONSEC = 2'h2
  } mode_t;

  // geometry
  localparam int         NUM_SLOTS     = 8;
  localparam int         NUM_PORTS     = 4;
  localparam int         PORT_PINS     = 8;
  localparam int         RIGHTS_W      = 12;

  // bridge address map: slot index in the top nibble
  localparam int         BR_ADDR_W     = 16;
  localparam int         BR_OFF_W      = 12;
  localparam logic [3:0] BR_SLOT_GPIO  = 4'h8;

  // register map, byte addresses
  localparam logic [7:0] SLOT_RIGHTS_BASE = 8'h00;
  localparam logic [7:0] PORT_RIGHTS_BASE = 8'h20;
  localparam logic [7:0] LOCK_ADDR        = 8'h30;
  localparam logic [7:0] STATUS_ADDR      = 8'h34;

  // status fields
  localparam int         ST_BR_ERR     = 0;
  localparam int         ST_CFG_REJ    = 1;
  localparam int         ST_LOCKED     = 2;
  localparam int         ST_SLOT_LSB   = 4;
  localparam int         ST_MASTER     = 8;
  localparam int         ST_MODE_LSB   = 9;

  // every master and mode may read and write out of power-on reset
  localparam logic [RIGHTS_W-1:0] RIGHTS_RESET = 12'hfff;

  // combine privilege and secure attributes into a mode
  function automatic mode_t access_mode(input logic priv,
                                        input logic secure);
    if (priv)
      return MODE_PRIV_SECURE;
    else if (secure)
      return MODE_USER_SECURE;
    else
      return MODE_USER_NONSEC;
  endfunction : access_mode

  // rights bit = mode*4 + master*2 + write
  function automatic logic permitted(input logic [RIGHTS_W-1:0] rights,
                                     input logic                master,
                                     input mode_t               mode,
                                     input logic                wr);
    logic [3:0] idx;
    idx = {mode, master, wr};
    return rights[idx];
  endfunction : permitted

endpackage : access_guard_pkg

// ==== hdl/gpio_port_bank.sv ====
/*
  Output latches of the eight-pin I/O ports with two write ports and two
  registered read ports; reads sample the pin inputs.
  Assumes the caller has already judged every access; a disabled read
  returns zero in the following cycle.
*/
`timescale 1ns/1ps
module gpio_port_bank
  import access_guard_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic [NUM_PORTS*PORT_PINS-1:0] pin_in,
  input  wire logic                         wr_en_a,
  input  wire logic [1:0]                   wr_port_a,
  input  wire logic [PORT_PINS-1:0]         wr_data_a,
  input  wire logic                         wr_en_b,
  input  wire logic [1:0]                   wr_port_b,
  input  wire logic [PORT_PINS-1:0]         wr_data_b,
  input  wire logic                         rd_en_a,
  input  wire logic [1:0]                   rd_port_a,
  input  wire logic                         rd_en_b,
  input  wire logic [1:0]                   rd_port_b,
  output logic      [PORT_PINS-1:0]         rd_data_a,
  output logic      [PORT_PINS-1:0]         rd_data_b,
  output logic      [NUM_PORTS*PORT_PINS-1:0] port_out
);

  // output latches; the core port write lands last and wins a collision
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      port_out <= '0;
    else
    begin
      if (wr_en_a)
        port_out[wr_port_a*PORT_PINS +: PORT_PINS] <= wr_data_a;
      if (wr_en_b)
        port_out[wr_port_b*PORT_PINS +: PORT_PINS] <= wr_data_b;
    end
  end

  // registered reads, zero when not enabled
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_data_a <= '0;
      rd_data_b <= '0;
    end
    else
    begin
      rd_data_a <= rd_en_a ? pin_in[rd_port_a*PORT_PINS +: PORT_PINS] : '0;
      rd_data_b <= rd_en_b ? pin_in[rd_port_b*PORT_PINS +: PORT_PINS] : '0;
    end
  end

endmodule : gpio_port_bank

// ==== hdl/peripheral_gpio_access_guard.sv ====
/*
  Peripheral bridge with per-slot access rights, I/O port rights shared by
  the bridge and the single-cycle core port, and a lockable configuration.
  Assumes peripherals answer PS_RDATA in the cycle they are selected, and
  that POR_N is asserted together with RESETN at power-on.
*/
`timescale 1ns/1ps
module peripheral_gpio_access_guard
  import access_guard_pkg::*;
(
  input  wire logic                 SYS_CLK,
  input  wire logic                 RESETN,
  input  wire logic                 POR_N,
  // configuration register port
  input  wire logic [7:0]           REG_ADDR,
  input  wire logic [31:0]          REG_WDATA,
  input  wire logic                 REG_WR,
  input  wire logic                 REG_RD,
  input  wire logic                 REG_PRIV,
  output logic      [31:0]          REG_RDATA,
  // bridge request from the crossbar
  input  wire logic                 BR_VALID,
  input  wire logic                 BR_WRITE,
  input  wire logic [BR_ADDR_W-1:0] BR_ADDR,
  input  wire logic [31:0]          BR_WDATA,
  input  wire logic                 BR_MASTER,
  input  wire logic                 BR_PRIV,
  input  wire logic                 BR_SECURE,
  output logic                      BR_DONE,
  output logic                      BR_ERROR,
  output logic      [31:0]          BR_RDATA,
  // peripheral slot side
  output logic      [NUM_SLOTS-1:0] PS_SEL,
  output logic                      PS_WRITE,
  output logic      [BR_OFF_W-1:0]  PS_ADDR,
  output logic      [31:0]          PS_WDATA,
  input  wire logic [NUM_SLOTS*32-1:0] PS_RDATA,
  // single-cycle core port
  input  wire logic                 CP_VALID,
  input  wire logic                 CP_WRITE,
  input  wire logic [1:0]           CP_PORT,
  input  wire logic [PORT_PINS-1:0] CP_WDATA,
  input  wire logic                 CP_PRIV,
  input  wire logic                 CP_SECURE,
  output logic      [PORT_PINS-1:0] CP_RDATA,
  // pins
  input  wire logic [NUM_PORTS*PORT_PINS-1:0] GPIO_IN,
  output logic      [NUM_PORTS*PORT_PINS-1:0] GPIO_OUT,
  output logic                      BOOT_PRIV_SECURE
);

  // rights tables and the configuration lock
  logic [RIGHTS_W-1:0]  slot_rights_reg [NUM_SLOTS];
  logic [RIGHTS_W-1:0]  port_rights_reg [NUM_PORTS];
  logic                 lock_reg;
  logic                 rst_any_n;

  // bridge decode and judgement
  logic [3:0]           br_slot;
  logic                 br_is_per;
  logic                 br_is_gpio;
  logic [2:0]           br_idx;
  logic [1:0]           br_port;
  logic [RIGHTS_W-1:0]  br_rights;
  mode_t                br_mode;
  logic                 br_ok;
  logic                 br_per_go;
  logic                 br_gpio_go;

  // core port judgement
  mode_t                cp_mode;
  logic                 cp_ok;

  // configuration write decode
  logic                 cfg_wr;
  logic                 cfg_ok;
  logic                 is_slot_addr;
  logic                 is_port_addr;
  logic [2:0]           reg_slot;
  logic [1:0]           reg_port;

  // bridge answer registers
  logic                 br_done_reg;
  logic                 br_error_reg;
  logic [31:0]          br_rdata_reg;
  logic                 br_gpio_rd_reg;
  logic [PORT_PINS-1:0] bank_rd_a;

  // status flags and captured error details
  logic                 br_err_flag_reg;
  logic                 cfg_rej_flag_reg;
  logic [3:0]           err_slot_reg;
  logic                 err_master_reg;
  mode_t                err_mode_reg;

  // register read path and boot mode
  logic [31:0]          reg_rdata_reg;
  logic [31:0]          reg_rdata_next;
  logic [31:0]          status_word;
  logic                 boot_ps_reg;

  // power-on reset also resets everything the warm reset covers
  assign rst_any_n = RESETN & POR_N;
  // rights and lock watch POR_N alone, so a warm reset keeps them

  // bridge decode and rights lookup, judged in the request cycle
  assign br_slot    = BR_ADDR[BR_ADDR_W-1 -: 4];
  assign br_is_per  = ~br_slot[3];
  assign br_is_gpio = (br_slot == BR_SLOT_GPIO);
  assign br_idx     = br_slot[2:0];
  assign br_port    = BR_ADDR[3:2];
  assign br_mode    = access_mode(BR_PRIV, BR_SECURE);
  assign br_rights  = br_is_per ? slot_rights_reg[br_idx]
                                : port_rights_reg[br_port];
  // an unmapped slot fails the first term and always errors
  assign br_ok      = (br_is_per | br_is_gpio) &&
                      permitted(br_rights, BR_MASTER, br_mode,
                                BR_WRITE);
  assign br_per_go  = BR_VALID & br_is_per & br_ok;
  assign br_gpio_go = BR_VALID & br_is_gpio & br_ok;

  // forward permitted transactions to the addressed slot only
  // denied or unmapped requests never reach a slot
  assign PS_SEL   = br_per_go ? NUM_SLOTS'(1) << br_idx : '0;
  assign PS_WRITE = br_per_go & BR_WRITE;
  assign PS_ADDR  = BR_ADDR[BR_OFF_W-1:0];
  assign PS_WDATA = BR_WDATA;

  // core port is always the core master
  assign cp_mode = access_mode(CP_PRIV, CP_SECURE);
  assign cp_ok   = permitted(port_rights_reg[CP_PORT], MASTER_CORE,
                             cp_mode, CP_WRITE);

  // port latches shared by the bridge and the core port
  // bridge writes enter on port a, core port writes on port b
  gpio_port_bank u_bank
  (
    .clk       (SYS_CLK),
    .rst_n     (rst_any_n),
    .pin_in    (GPIO_IN),
    .wr_en_a   (br_gpio_go & BR_WRITE),
    .wr_port_a (br_port),
    .wr_data_a (BR_WDATA[PORT_PINS-1:0]),
    .wr_en_b   (CP_VALID & CP_WRITE & cp_ok),
    .wr_port_b (CP_PORT),
    .wr_data_b (CP_WDATA),
    .rd_en_a   (br_gpio_go & ~BR_WRITE),
    .rd_port_a (br_port),
    .rd_en_b   (CP_VALID & ~CP_WRITE & cp_ok),
    .rd_port_b (CP_PORT),
    .rd_data_a (bank_rd_a),
    .rd_data_b (CP_RDATA),
    .port_out  (GPIO_OUT)
  );

  // bridge answer one cycle after the request
  always_ff @(posedge SYS_CLK)
  begin
    if (!rst_any_n)
    begin
      br_done_reg    <= 1'b0;
      br_error_reg   <= 1'b0;
      br_rdata_reg   <= '0;
      br_gpio_rd_reg <= 1'b0;
    end
    else
    begin
      br_done_reg    <= BR_VALID;
      br_error_reg   <= BR_VALID & ~br_ok;
      br_gpio_rd_reg <= br_gpio_go & ~BR_WRITE;
      br_rdata_reg   <= (br_per_go & ~BR_WRITE) ?
                        PS_RDATA[br_idx*32 +: 32] : '0;
    end
  end

  assign BR_DONE  = br_done_reg;
  assign BR_ERROR = br_error_reg;
  assign BR_RDATA = br_gpio_rd_reg ? {24'h000000, bank_rd_a}
                                   : br_rdata_reg;

  // configuration write decode
  assign is_slot_addr = (REG_ADDR[7:5] == SLOT_RIGHTS_BASE[7:5]) &&
                        (REG_ADDR[1:0] == 2'h0);
  assign is_port_addr = (REG_ADDR[7:4] == PORT_RIGHTS_BASE[7:4]) &&
                        (REG_ADDR[1:0] == 2'h0);
  assign reg_slot     = REG_ADDR[4:2];
  assign reg_port     = REG_ADDR[3:2];
  assign cfg_wr       = REG_WR & (is_slot_addr | is_port_addr |
                                  (REG_ADDR == LOCK_ADDR));
  assign cfg_ok       = cfg_wr & REG_PRIV & ~lock_reg;

  // rights tables survive warm resets, only power-on reloads them with RIGHTS_RESET
  always_ff @(posedge SYS_CLK)
  begin
    if (!POR_N)
    begin
      for (int i = 0; i < NUM_SLOTS; i++)
        slot_rights_reg[i] <= RIGHTS_RESET;
      for (int i = 0; i < NUM_PORTS; i++)
        port_rights_reg[i] <= RIGHTS_RESET;
    end
    else if (cfg_ok)
    begin
      if (is_slot_addr)
        slot_rights_reg[reg_slot] <= REG_WDATA[RIGHTS_W-1:0];
      if (is_port_addr)
        port_rights_reg[reg_port] <= REG_WDATA[RIGHTS_W-1:0];
    end
  end

  // lock is sticky, only power-on reset releases it
  // the lock write itself must be privileged and unlocked
  always_ff @(posedge SYS_CLK)
  begin
    if (!POR_N)
      lock_reg <= 1'b0;
    else if (cfg_ok && REG_ADDR == LOCK_ADDR && REG_WDATA[0])
      lock_reg <= 1'b1;
  end

  // sticky status flags; a new event beats a same-cycle clear
  // captured slot, master and mode stay until the next bridge error or reset
  always_ff @(posedge SYS_CLK)
  begin
    if (!rst_any_n)
    begin
      br_err_flag_reg  <= 1'b0;
      cfg_rej_flag_reg <= 1'b0;
      err_slot_reg     <= '0;
      err_master_reg   <= MASTER_CORE;
      err_mode_reg     <= MODE_PRIV_SECURE;
    end
    else
    begin
      if (REG_WR && REG_PRIV && REG_ADDR == STATUS_ADDR)
      begin
        if (REG_WDATA[ST_BR_ERR])
          br_err_flag_reg <= 1'b0;
        if (REG_WDATA[ST_CFG_REJ])
          cfg_rej_flag_reg <= 1'b0;
      end
      if (BR_VALID && !br_ok)
      begin
        br_err_flag_reg <= 1'b1;
        err_slot_reg    <= br_slot;
        err_master_reg  <= BR_MASTER;
        err_mode_reg    <= br_mode;
      end
      if (cfg_wr && !cfg_ok)
        cfg_rej_flag_reg <= 1'b1;
    end
  end

  // status word assembly
  always_comb
  begin
    status_word                               = '0;
    status_word[ST_BR_ERR]                    = br_err_flag_reg;
    status_word[ST_CFG_REJ]                   = cfg_rej_flag_reg;
    status_word[ST_LOCKED]                    = lock_reg;
    status_word[ST_SLOT_LSB +: 4]             = err_slot_reg;
    status_word[ST_MASTER]                    = err_master_reg;
    status_word[ST_MODE_LSB +: 2]             = err_mode_reg;
  end

  // register read mux, unmapped addresses read zero
  // reads need no privilege; rights sit in the low twelve bits
  always_comb
  begin
    reg_rdata_next = '0;
    if (is_slot_addr)
      reg_rdata_next[RIGHTS_W-1:0] = slot_rights_reg[reg_slot];
    else if (is_port_addr)
      reg_rdata_next[RIGHTS_W-1:0] = port_rights_reg[reg_port];
    else if (REG_ADDR == LOCK_ADDR)
      reg_rdata_next[0] = lock_reg;
    else if (REG_ADDR == STATUS_ADDR)
      reg_rdata_next = status_word;
  end

  // read data stands only in the cycle after the strobe
  // zero outside the answer cycle, so no stale word lingers
  always_ff @(posedge SYS_CLK)
  begin
    if (!rst_any_n)
      reg_rdata_reg <= '0;
    else
      reg_rdata_reg <= REG_RD ? reg_rdata_next : '0;
  end

  assign REG_RDATA = reg_rdata_reg;

  // core starts privileged secure; ends at its first user-mode access
  // dma accesses never end the boot mode
  always_ff @(posedge SYS_CLK)
  begin
    if (!rst_any_n)
      boot_ps_reg <= 1'b1;
    else if ((CP_VALID && !CP_PRIV) ||
             (BR_VALID && BR_MASTER == MASTER_CORE && !BR_PRIV))
      boot_ps_reg <= 1'b0;
  end

  assign BOOT_PRIV_SECURE = boot_ps_reg;

endmodule : peripheral_gpio_access_guard

// ==== tb/access_guard_checker.sv ====
/*
  Port-level assertions for the bridge, core port and boot mode.
  Assumes it is bound to the guard's top module; one clock domain.
*/
`timescale 1ns/1ps
module access_guard_checker
(
  input wire logic        SYS_CLK,
  input wire logic        RESETN,
  input wire logic        POR_N,
  input wire logic        BR_VALID,
  input wire logic        BR_WRITE,
  input wire logic [15:0] BR_ADDR,
  input wire logic        BR_DONE,
  input wire logic        BR_ERROR,
  input wire logic [31:0] BR_RDATA,
  input wire logic [7:0]  PS_SEL,
  input wire logic [11:0] PS_ADDR,
  input wire logic        CP_VALID,
  input wire logic        CP_WRITE,
  input wire logic [7:0]  CP_RDATA,
  input wire logic [31:0] GPIO_OUT,
  input wire logic        BOOT_PRIV_SECURE
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESETN || !POR_N);

  // a bridge request and the answer owed to it
  sequence br_req;
    BR_VALID;
  endsequence
  sequence br_ans;
    BR_DONE ##0 (!BR_ERROR || BR_RDATA == 32'h0);
  endsequence

  // bridge answers exactly one cycle after each request
  done_after_req_a: assert property (br_req |=> br_ans)
    else $error("bridge request not answered next cycle");
  done_needs_req_a: assert property (BR_DONE |-> $past(BR_VALID))
    else $error("bridge done without a request");
  err_with_done_a: assert property (BR_ERROR |-> BR_DONE)
    else $error("bridge error outside done");
  // slot select follows the request address in the same cycle
  sel_from_addr_a: assert property (PS_SEL != 8'h0 |->
    BR_VALID && !BR_ADDR[15] && PS_SEL == (8'h1 << BR_ADDR[14:12])
    && PS_ADDR == BR_ADDR[11:0])
    else $error("slot select does not match request");
  blocked_err_a: assert property (br_req ##0
    (!BR_ADDR[15] && PS_SEL == 8'h0) |=> BR_ERROR)
    else $error("blocked slot access not flagged");
  granted_ok_a: assert property (br_req ##0 (PS_SEL != 8'h0)
    |=> !BR_ERROR)
    else $error("granted slot access flagged");
  // core port reads zero unless a read was made
  cp_zero_a: assert property (!(CP_VALID && !CP_WRITE)
    |=> CP_RDATA == 8'h0)
    else $error("core port data without a read");
  gpio_hold_a: assert property (!(CP_VALID && CP_WRITE) &&
    !(BR_VALID && BR_WRITE) |=> $stable(GPIO_OUT))
    else $error("port latch changed without a write");
  // the first cycle after any reset release finds boot mode set
  boot_rise_a: assert property ($rose(RESETN && POR_N) |->
    BOOT_PRIV_SECURE)
    else $error("boot mode not set after reset");
endmodule : access_guard_checker

bind peripheral_gpio_access_guard access_guard_checker u_chk (.*);

// ==== tb/periph_slot_model.sv ====
/*
  Peripheral slot model: eight slots, one word each, written when selected.
  Assumes select and write strobe come straight from the bridge.
*/
`timescale 1ns/1ps
module periph_slot_model
(
  input  wire logic         clk,
  input  wire logic [7:0]   sel,
  input  wire logic         write,
  input  wire logic [31:0]  wdata,
  output logic      [255:0] rdata
);
  logic [31:0] mem [8];

  // each slot starts with a word that names it
  initial
  begin
    for (int i = 0; i < 8; i++)
      mem[i] = 32'h51000000 + i;
  end

  // a selected slot stores a write at the clock edge
  always @(posedge clk)
  begin
    for (int i = 0; i < 8; i++)
      if (sel[i] && write)
        mem[i] <= wdata;
  end

  // an unselected slot shows the inverse so no stale word passes
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      rdata[i*32 +: 32] = sel[i] ? mem[i] : ~mem[i];
  end
endmodule : periph_slot_model

// ==== tb/test_peripheral_gpio_access_guard.sv ====
/*
  Bench: register, bridge and core-port tasks run rights, mode and lock
  tests. Assumes the slot model answers all peripheral slots.
*/
`timescale 1ns/1ps
module test_peripheral_gpio_access_guard;
  logic         SYS_CLK = 1'b0, RESETN = 1'b0, POR_N = 1'b0;
  logic [7:0]   REG_ADDR = 8'h0;
  logic [31:0]  REG_WDATA = 32'h0, BR_WDATA = 32'h0;
  logic         REG_WR = 1'b0, REG_RD = 1'b0, REG_PRIV = 1'b0;
  logic         BR_VALID = 1'b0, BR_WRITE = 1'b0, BR_MASTER = 1'b0;
  logic         BR_PRIV = 1'b0, BR_SECURE = 1'b0;
  logic [15:0]  BR_ADDR = 16'h0;
  logic         CP_VALID = 1'b0, CP_WRITE = 1'b0;
  logic         CP_PRIV = 1'b0, CP_SECURE = 1'b0;
  logic [1:0]   CP_PORT = 2'h0;
  logic [7:0]   CP_WDATA = 8'h0, CP_RDATA, PS_SEL;
  logic [31:0]  GPIO_IN = 32'h8c4a31e7, GPIO_OUT;
  logic [31:0]  REG_RDATA, BR_RDATA, PS_WDATA;
  logic         BR_DONE, BR_ERROR, PS_WRITE, BOOT_PRIV_SECURE;
  logic [11:0]  PS_ADDR;
  logic [255:0] PS_RDATA;
  logic [31:0]  sh [8];
  int           fails = 0, checks = 0, cyc = 0;

  peripheral_gpio_access_guard u_dut (.*);
  periph_slot_model u_slots (.clk(SYS_CLK), .sel(PS_SEL),
    .write(PS_WRITE), .wdata(PS_WDATA), .rdata(PS_RDATA));

  // clock and hang guard
  always #5 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic do_reset(input logic por);
    @(posedge SYS_CLK);
    RESETN <= 1'b0;
    POR_N <= !por;
    repeat (3) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    POR_N <= 1'b1;
  endtask : do_reset

  // register write, or read compared against d in the following cycle
  task automatic reg_acc(input logic wr, input logic [7:0] a,
                         input logic [31:0] d, input logic p);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_PRIV <= p;
    REG_WR <= wr;
    REG_RD <= !wr;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
    REG_RD <= 1'b0;
    #1 if (!wr) chk(REG_RDATA, d);
  endtask : reg_acc

  // bridge access to port 1 offset; md 0 priv, 1 user secure, 2 nonsecure
  task automatic br(input logic wr, input logic [15:0] a,
                    input logic [31:0] d, input logic m,
                    input logic [1:0] md, input logic err);
    logic [7:0] old;
    old = GPIO_OUT[15:8];
    @(posedge SYS_CLK);
    BR_VALID <= 1'b1;
    BR_WRITE <= wr;
    BR_ADDR <= a;
    BR_WDATA <= d;
    BR_MASTER <= m;
    BR_PRIV <= md == 2'h0;
    BR_SECURE <= md != 2'h2;
    @(posedge SYS_CLK);
    BR_VALID <= 1'b0;
    #1 chk({BR_DONE, BR_ERROR}, {1'b1, err});
    if (!wr && !err)
      chk(BR_RDATA, a[15] ? {24'h0, GPIO_IN[15:8]} : sh[a[14:12]]);
    if (wr && a[15:12] == 4'h8)
      chk(GPIO_OUT[15:8], err ? old : d[7:0]);
    if (wr && !err && !a[15])
      sh[a[14:12]] = d;
  endtask : br

  task automatic cp(input logic wr, input logic [7:0] d,
                    input logic [1:0] md, input logic ok);
    logic [7:0] old;
    old = GPIO_OUT[15:8];
    @(posedge SYS_CLK);
    CP_VALID <= 1'b1;
    CP_WRITE <= wr;
    CP_PORT <= 2'h1;
    CP_WDATA <= d;
    CP_PRIV <= md == 2'h0;
    CP_SECURE <= md != 2'h2;
    @(posedge SYS_CLK);
    CP_VALID <= 1'b0;
    #1 if (wr) chk(GPIO_OUT[15:8], ok ? d : old);
    else chk(CP_RDATA, ok ? GPIO_IN[15:8] : 8'h0);
  endtask : cp

  // every mode, master and direction against a rights word
  task automatic combos(input logic [3:0] s, input logic [11:0] r);
    for (int i = 0; i < 12; i++)
    begin
      br(i[0], {s, 12'h004}, 32'h5e000000 + i * 17, i[1], i[3:2],
         !r[i]);
      if (s == 4'h8 && !i[1])
        cp(i[0], 8'hc3 ^ i[7:0], i[3:2], r[i]);
    end
  endtask : combos

  initial
  begin
    for (int i = 0; i < 8; i++)
      sh[i] = 32'h51000000 + i;
    do_reset(1'b1);
    #1 chk(BOOT_PRIV_SECURE, 1'b1);
    reg_acc(0, 8'h00, 32'hfff, 0);
    reg_acc(0, 8'h2c, 32'hfff, 0);
    reg_acc(0, 8'h34, 32'h0, 0);
    reg_acc(0, 8'h3c, 32'h0, 0);
    $display("test reset done");
    reg_acc(1, 8'h0c, 32'h0, 0);
    reg_acc(0, 8'h0c, 32'hfff, 0);
    reg_acc(0, 8'h34, 32'h2, 0);
    reg_acc(1, 8'h34, 32'h3, 1);
    $display("test privilege done");
    reg_acc(1, 8'h0c, 32'h0a5, 1);
    reg_acc(0, 8'h0c, 32'h0a5, 0);
    combos(4'h3, 12'h0a5);
    combos(4'h2, 12'hfff);
    combos(4'h9, 12'h000);
    $display("test bridge done");
    reg_acc(1, 8'h24, 32'h0a5, 1);
    combos(4'h8, 12'h0a5);
    chk(BOOT_PRIV_SECURE, 1'b0);
    reg_acc(1, 8'h34, 32'h3, 1);
    br(1, 16'h8004, 32'h0, 1, 2'h2, 1);
    reg_acc(0, 8'h34, 32'h581, 0);
    reg_acc(1, 8'h34, 32'h3, 1);
    $display("test port done");
    reg_acc(1, 8'h30, 32'h1, 1);
    reg_acc(1, 8'h24, 32'hfff, 1);
    reg_acc(0, 8'h34, 32'h586, 0);
    do_reset(1'b0);
    #1 chk(BOOT_PRIV_SECURE, 1'b1);
    reg_acc(1, 8'h24, 32'h0, 1);
    reg_acc(0, 8'h24, 32'h0a5, 0);
    do_reset(1'b1);
    reg_acc(0, 8'h24, 32'hfff, 0);
    reg_acc(1, 8'h24, 32'h0, 1);
    reg_acc(0, 8'h24, 32'h0, 0);
    $display("test lock done");
    test_done();
  end
endmodule : test_peripheral_gpio_access_guard
